// *** hdl/lds_pkg.sv ***
`default_nettype none
package lds_pkg;
  // ----------------------------------------------------------------
  // link geometry
  // ----------------------------------------------------------------
  localparam int LANES = 3;
  localparam int BITS = 7;
  localparam int WORD_W = LANES * BITS;
  localparam logic [2:0] FRAME_LAST = 3'h6;

  typedef logic [BITS-1:0] lds_frame_t;

  typedef struct packed {
    lds_frame_t lane2;
    lds_frame_t lane1;
    lds_frame_t lane0;
  } lds_word_t;

  localparam lds_word_t WORD_ZERO = '0;

  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_LOCK = 2'h1,
    ST_RUN = 2'h3
  } lds_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_MS = 1;
  localparam int LOCK_CYCLES = (LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int LOCK_CNT_W = 16;
  localparam int OFF_TIME_NS = 400;
  localparam int OFF_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// *** hdl/lds_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module lds_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // lds_sync
`default_nettype wire

// *** hdl/lds_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module lds_fifo #(
  parameter int W = 21,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic valid_r;
  logic [W-1:0] data_r;
  wire push = in_valid && in_ready;
  wire take = (count_r != '0) && (!valid_r || out_ready);

  assign in_ready = count_r != FULL_CNT;
  assign out_valid = valid_r;
  assign out_data = data_r;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(take);

  // storage has no reset; pointers decide what is live
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      valid_r <= 1'b0;
      data_r <= '0;
    end else if (flush) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
      valid_r <= 1'b0;
      data_r <= '0;
    end else begin
      wptr_r <= push ? wptr_r + 1'b1 : wptr_r;
      rptr_r <= take ? rptr_r + 1'b1 : rptr_r;
      count_r <= count_nxt;
      if (take) begin
        data_r <= mem[rptr_r];
        valid_r <= 1'b1;
      end else if (out_ready) begin
        valid_r <= 1'b0;
      end
    end
  end
endmodule // lds_fifo
`default_nettype wire

// *** hdl/lds_deser.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - each of three lanes shifts into its own register giving seven parallel bits
// - three data lanes plus a forwarded clock lane expand to 21 bits
// - bits enter the lane registers at seven times the forwarded clock rate
// - bit clock is an input; output clock is generated from the system clock, one pulse per word
// - one 21-bit word is transferred per forwarded clock period
// - each word is valid at the rising edge of the output clock
// - shutdown low stops output clocking and disables the lane receivers
// - shutdown low clears shift registers, held word, buffer pointers and output word; buffer storage keeps its contents
// - lock achieved within 1 ms of shutdown release; words invalid before then
// - off state reached within 400 ns of shutdown going low
module lds_deser #(
  parameter int LOCK_CYC = lds_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_clk,
  input wire logic lane_clock_in,
  input wire logic [lds_pkg::LANES-1:0] lane_data_in,
  input wire logic shutdown_clear_n,
  input wire logic out_hold,
  output lds_pkg::lds_word_t parallel_word,
  output logic word_clock_out,
  output logic word_valid,
  output logic lane_rx_enable,
  output logic link_overrun
);
  import lds_pkg::*;

  localparam int OFF_MAX = OFF_CYCLES;
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYC - 1);
  localparam logic [2:0] CNT_PARK = FRAME_LAST + 3'h1;

  function automatic lds_frame_t shift_in(input lds_frame_t f, input logic b);
    shift_in = {f[BITS-2:0], b};
  endfunction

  // ----------------------------------------------------------------
  // link domain: bit clock
  // ----------------------------------------------------------------
  logic link_rst_n;
  logic [LANES+1:0] lpin_q;
  logic ack_l;
  logic ack_r;
  lds_frame_t [LANES-1:0] sh_r;
  lds_frame_t [LANES-1:0] frame_w;
  lds_word_t hold_r;
  logic fclk_d_r;
  logic req_tog_r;
  logic overrun_r;
  logic [2:0] bit_cnt_r;
  logic seen_r;

  lds_sync #(.W(1)) u_lrst (
    .clk(bit_clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(link_rst_n)
  );

  // pins and shutdown pass two flops; equal delay keeps lanes aligned
  lds_sync #(.W(LANES+2)) u_lpin (
    .clk(bit_clk),
    .rst_n(link_rst_n),
    .d({shutdown_clear_n, lane_clock_in, lane_data_in}),
    .q(lpin_q)
  );

  lds_sync #(.W(1)) u_ack (
    .clk(bit_clk),
    .rst_n(link_rst_n),
    .d(ack_r),
    .q(ack_l)
  );

  wire lsd_n = lpin_q[LANES+1];
  wire fclk_q = lpin_q[LANES];
  wire [LANES-1:0] lbit = lpin_q[LANES-1:0];
  wire fclk_rise = fclk_q && !fclk_d_r;
  wire busy = req_tog_r != ack_l;
  wire capture = fclk_rise && lsd_n;
  wire lds_word_t frame_word = {frame_w[2], frame_w[1], frame_w[0]};

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign frame_w[i] = shift_in(sh_r[i], lbit[i]);
  end

  always_ff @(posedge bit_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sh_r <= '0;
      hold_r <= WORD_ZERO;
      fclk_d_r <= 1'b0;
      req_tog_r <= 1'b0;
      overrun_r <= 1'b0;
      bit_cnt_r <= '0;
      seen_r <= 1'b0;
    end else if (!lsd_n) begin
      sh_r <= '0;
      hold_r <= WORD_ZERO;
      fclk_d_r <= 1'b0;
      req_tog_r <= 1'b0;
      overrun_r <= 1'b0;
      bit_cnt_r <= '0;
      seen_r <= 1'b0;
    end else begin
      sh_r <= frame_w;
      fclk_d_r <= fclk_q;
      // a silent forwarded clock parks the count, so a restart is not taken as a short frame
      bit_cnt_r <= fclk_rise ? 3'h0 : (bit_cnt_r == CNT_PARK ? CNT_PARK : bit_cnt_r + 3'h1);
      seen_r <= seen_r || fclk_rise;
      // a word arriving while the last is still crossing is lost, flagged
      if (capture && busy) begin
        overrun_r <= 1'b1;
      end
      if (capture && !busy) begin
        hold_r <= frame_word;
        req_tog_r <= ~req_tog_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain
  // ----------------------------------------------------------------
  logic sys_rst_n;
  logic sd_q;
  logic [1:0] lnk_s;
  lds_state_t st_r;
  lds_state_t st_nxt;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  lds_word_t word_r;
  logic oclk_r;
  logic pend_r;
  logic valid_r;
  logic rx_en_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  lds_word_t fifo_out_data;

  lds_sync #(.W(1)) u_srst (
    .clk(clk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(sys_rst_n)
  );

  lds_sync #(.W(1)) u_ssd (
    .clk(clk),
    .rst_n(sys_rst_n),
    .d(shutdown_clear_n),
    .q(sd_q)
  );

  lds_sync #(.W(2)) u_lnk (
    .clk(clk),
    .rst_n(sys_rst_n),
    .d({overrun_r, req_tog_r}),
    .q(lnk_s)
  );

  wire req_s = lnk_s[0];
  wire new_word = req_s != ack_r;
  wire run = st_r == ST_RUN;
  wire push_vld = new_word && run;
  // words before lock are acknowledged and dropped
  wire accept = new_word && (!run || fifo_in_ready);
  wire pop = fifo_out_valid && run && !oclk_r && !pend_r && !out_hold;
  wire lock_done = lock_cnt_r == LOCK_LAST;

  // hold_r is steady while the toggle is unacknowledged
  lds_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(sys_rst_n),
    .flush(!sd_q),
    .in_valid(push_vld),
    .in_ready(fifo_in_ready),
    .in_data(hold_r),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF: begin
        st_nxt = sd_q ? ST_LOCK : ST_OFF;
      end
      ST_LOCK: begin
        st_nxt = !sd_q ? ST_OFF : (lock_done ? ST_RUN : ST_LOCK);
      end
      ST_RUN: begin
        st_nxt = sd_q ? ST_RUN : ST_OFF;
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      st_r <= ST_OFF;
      lock_cnt_r <= '0;
      ack_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      lock_cnt_r <= (st_r == ST_LOCK && sd_q) ? lock_cnt_r + 1'b1 : '0;
      ack_r <= !sd_q ? 1'b0 : (accept ? req_s : ack_r);
    end
  end

  // output stage: load, then rise, then fall; a word spans both edges
  always_ff @(posedge clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      word_r <= WORD_ZERO;
      oclk_r <= 1'b0;
      pend_r <= 1'b0;
      valid_r <= 1'b0;
      rx_en_r <= 1'b0;
    end else if (!sd_q) begin
      word_r <= WORD_ZERO;
      oclk_r <= 1'b0;
      pend_r <= 1'b0;
      valid_r <= 1'b0;
      rx_en_r <= 1'b0;
    end else begin
      rx_en_r <= 1'b1;
      pend_r <= pop;
      oclk_r <= pend_r;
      valid_r <= run && (valid_r || pop);
      if (pop) begin
        word_r <= fifo_out_data;
      end
    end
  end

  assign parallel_word = word_r;
  assign word_clock_out = oclk_r;
  assign word_valid = valid_r;
  assign lane_rx_enable = rx_en_r;
  assign link_overrun = lnk_s[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_load;
    pop;
  endsequence

  sequence s_rise;
    !oclk_r ##1 oclk_r;
  endsequence

  sequence s_gap;
    !pop ##1 !pop;
  endsequence

  a_frame_seven_bits: assert property (
    @(posedge bit_clk) disable iff (!link_rst_n)
    (fclk_rise && seen_r && lsd_n && bit_cnt_r != CNT_PARK) |-> bit_cnt_r == FRAME_LAST)
    else $error("forwarded clock edge not seven bits after the last");

  a_capture_word: assert property (
    @(posedge bit_clk) disable iff (!link_rst_n)
    (capture && !busy) |=> (hold_r == $past(frame_word)) && (req_tog_r != $past(req_tog_r)))
    else $error("captured word not held for crossing");

  a_link_clear: assert property (
    @(posedge bit_clk) disable iff (!link_rst_n)
    !lsd_n |=> (sh_r == '0) && (hold_r == WORD_ZERO) && !overrun_r)
    else $error("lane registers not cleared in shutdown");

  a_off_time: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    ($fell(shutdown_clear_n) ##1 !shutdown_clear_n [*2])
      |-> ##[0:OFF_MAX] (!rx_en_r && !oclk_r && word_r == WORD_ZERO))
    else $error("off state not reached in time");

  a_clock_stopped: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (st_r == ST_OFF && !sd_q) |=> !oclk_r && !pend_r && !rx_en_r)
    else $error("output clock running while shut down");

  a_load_then_rise: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (s_load and sd_q) ##1 sd_q |-> s_rise ##0 $stable(word_r))
    else $error("loaded word not followed by output clock rise");

  a_word_stable: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    ($rose(oclk_r) && sd_q) |-> $stable(word_r) ##1 (!oclk_r && ($stable(word_r) || !sd_q)))
    else $error("word changed around output clock edge");

  a_invalid_unlocked: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (st_r != ST_RUN) |=> !valid_r && !pend_r)
    else $error("word presented before lock");

  a_lock_bound: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (st_r == ST_LOCK && sd_q && lock_done) |=> st_r == ST_RUN)
    else $error("lock count expired without entering run");

  a_hold_steady: assert property (
    @(posedge bit_clk) disable iff (!link_rst_n)
    (lsd_n && busy) |=> $stable(hold_r) && $stable(req_tog_r))
    else $error("held word or request moved during crossing");

  a_overrun_sticky: assert property (
    @(posedge bit_clk) disable iff (!link_rst_n)
    (overrun_r && lsd_n) |=> overrun_r)
    else $error("overrun flag dropped without shutdown");

  a_pop_spacing: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    s_load |=> s_gap)
    else $error("next word loaded within one output clock period");

  a_valid_after_load: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (s_load and sd_q) |=> valid_r)
    else $error("loaded word not marked valid");

  a_rx_enable_on: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (sd_q && st_r != ST_OFF) |-> rx_en_r)
    else $error("lane receivers off outside shutdown");

  a_fifo_flush: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    !sd_q |=> !fifo_out_valid)
    else $error("buffer not cleared in shutdown");

  a_lock_hold: assert property (
    @(posedge clk) disable iff (!sys_rst_n)
    (st_r == ST_LOCK && sd_q && !lock_done) |=> st_r == ST_LOCK)
    else $error("run entered before lock count expired");
endmodule // lds_deser
`default_nettype wire

// *** verif/lds_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lds_tx_model (
  input wire logic bit_clk,
  output logic lane_clock_in,
  output logic [2:0] lane_data
);
  import lds_pkg::*;
  lds_word_t q[$];
  lds_word_t cur;
  logic [2:0] k;
  logic busy;
  initial begin
    k = 3'h0;
    busy = 1'b0;
    cur = WORD_ZERO;
    lane_clock_in = 1'b0;
    lane_data = 3'h5;
  end
  function automatic void push(lds_word_t w);
    q.push_back(w);
  endfunction
  function automatic void flush();
    q.delete();
  endfunction
  // ----------------------------------------------------------------
  // one frame of seven slots, forwarded clock rises with the last slot
  // ----------------------------------------------------------------
  // forwarded rate is scaled down here; only the slot count matters to the receiver
  always @(negedge bit_clk) begin
    if (!busy && q.size() > 0) begin
      cur = q.pop_front();
      busy = 1'b1;
      k = 3'h0;
    end
    if (busy) begin
      lane_data <= {cur.lane2[3'h6 - k], cur.lane1[3'h6 - k], cur.lane0[3'h6 - k]};
      lane_clock_in <= (k == FRAME_LAST);
      if (k == FRAME_LAST) begin
        busy = 1'b0;
      end else begin
        k = k + 3'h1;
      end
    end else begin
      // idle: clock stands still, data keeps changing so stale bits cannot pass
      lane_data <= ~lane_data;
      lane_clock_in <= 1'b0;
    end
  end
endmodule // lds_tx_model
`default_nettype wire

// *** verif/lds_deser_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module lds_deser_tb;
  import lds_pkg::*;
  localparam int LOCK_SIM = 20;
  logic clk, bit_clk, rst_n, shutdown_clear_n, out_hold;
  logic lane_clock_in, word_clock_out, word_valid, lane_rx_enable, link_overrun;
  logic [2:0] lane_data_in;
  lds_word_t parallel_word;
  lds_word_t sent[$];
  int err_count, comparisons;

  lds_tx_model lds_tx_model_i (
    .bit_clk(bit_clk),
    .lane_clock_in(lane_clock_in),
    .lane_data(lane_data_in)
  );
  lds_deser #(.LOCK_CYC(LOCK_SIM)) lds_deser_i (
    .clk(clk),
    .rst_n(rst_n),
    .bit_clk(bit_clk),
    .lane_clock_in(lane_clock_in),
    .lane_data_in(lane_data_in),
    .shutdown_clear_n(shutdown_clear_n),
    .out_hold(out_hold),
    .parallel_word(parallel_word),
    .word_clock_out(word_clock_out),
    .word_valid(word_valid),
    .lane_rx_enable(lane_rx_enable),
    .link_overrun(link_overrun)
  );

  // ----------------------------------------------------------------
  // clocks, unrelated in phase
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    bit_clk = 1'b0;
    #7;
    forever #24 bit_clk = ~bit_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input lds_word_t w);
    sent.push_back(w);
    lds_tx_model_i.push(w);
  endtask
  // word is taken while the output clock is high, then must still stand
  task automatic expect_words(input int n);
    int t;
    lds_word_t w;
    repeat (n) begin
      t = 0;
      while (word_clock_out !== 1'b1 && t < 400) begin
        @(negedge clk);
        t++;
      end
      w = parallel_word;
      chk(w, sent.pop_front());
      @(negedge clk);
      chk(parallel_word, w);
    end
  endtask
  task automatic lock_wait();
    repeat (LOCK_SIM) begin
      @(negedge clk);
      chk({word_valid, word_clock_out}, 2'h0);
    end
    repeat (15) @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_stream();
    lds_word_t tbl[8];
    tbl = '{21'h000000, 21'h1FFFFF, 21'h155555, 21'h0AAAAA,
            21'h000001, 21'h100000, 21'h00007F, 21'h1FC000};
    foreach (tbl[i]) send(tbl[i]);
    expect_words(8);
    chk(word_valid, 1'b1);
    $display("test stream done");
  endtask
  // far side stalls until the buffer refuses, then drains in order
  task automatic t_stall();
    out_hold = 1'b1;
    for (int i = 0; i < 20; i++) send({7'(i), ~7'(i), 7'(i + 3)});
    repeat (160) @(negedge clk);
    chk(link_overrun, 1'b1);
    out_hold = 1'b0;
    // sixteen stored, one in the buffer's output register, one parked at the crossing
    expect_words(18);
    sent.delete();
    $display("test stall done");
  endtask
  task automatic t_shutdown();
    shutdown_clear_n = 1'b0;
    lds_tx_model_i.flush();
    repeat (8) @(negedge clk);
    chk(parallel_word, WORD_ZERO);
    chk(lane_rx_enable, 1'b0);
    chk({word_valid, link_overrun}, 2'h0);
    repeat (20) begin
      @(negedge clk);
      chk(word_clock_out, 1'b0);
    end
    shutdown_clear_n = 1'b1;
    lds_tx_model_i.push(21'h012345);
    lock_wait();
    chk(lane_rx_enable, 1'b1);
    $display("test shutdown done");
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    shutdown_clear_n = 1'b1;
    out_hold = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    lock_wait();
    $display("test lock done");
    t_stream();
    t_stall();
    t_shutdown();
    t_stream();
    stop_test();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule // lds_deser_tb
`default_nettype wire
